// ==== rtl/loop_ctrl_params.svh ====
// Offsets, field positions, encodings and timing figures of the loopback controller.
`ifndef LOOP_CTRL_PARAMS_SVH
`define LOOP_CTRL_PARAMS_SVH

// Register offsets.
`define REG_PATTERN_CTRL 8'h0C
`define REG_LOOP_CTRL 8'h0D
`define REG_CODE_LENGTHS 8'h0E
`define REG_TX_CODE 8'h0F
`define REG_RX_ACT_CODE 8'h10
`define REG_RX_DEACT_CODE 8'h11
`define REG_EDGE_SELECT 8'h15
`define REG_DETECT_STATUS 8'h16
`define REG_LOOP_STATUS 8'h17
`define REG_IRQ_FLAGS 8'h18

// Pattern control fields.
`define PC_PATT_LO 0
`define PC_PATT_HI 1
`define PC_CLK_SEL 2
`define PC_E1_MODE 3

// Loop control fields.
`define LC_ANALOG 0
`define LC_DIGITAL 1
`define LC_REMOTE 2
`define LC_AUTO 3

// Code length fields (each two bits wide, low bit given).
`define LEN_TX 0
`define LEN_ACT 2
`define LEN_DEACT 4

// Bit positions shared by edge select, detect status and interrupt flags.
`define BIT_ACT 0
`define BIT_DEACT 1

// Pattern select encodings.
`define PATT_NORMAL 2'h0
`define PATT_ONES 2'h1
`define PATT_PRBS 2'h2
`define PATT_LOOP 2'h3

// Loop select pin encodings.
`define PINS_ANALOG 2'h1
`define PINS_DIGITAL 2'h2
`define PINS_REMOTE 2'h3

// Synchroniser lanes.
`define SY_TXCLK 0
`define SY_TXDATA 1
`define SY_MREF 2
`define SY_RXCLK 3
`define SY_RXDATA 4
`define SY_PINMODE 5
`define SY_LP0 6
`define SY_LP1 7

// Code lengths and detector gap limit.
`define CODE_LEN_BASE 4'h5
`define GAP_PERIODS 5'h03
`define GAP_MAX 5'h1F
`define MASK_FULL 8'hFF

// Qualification times and master reference rates.
`define QUAL_SHORT_E1_MS 30
`define QUAL_SHORT_T1_MS 40
`define QUAL_LONG_MS 5100
`define MREF_E1_KHZ 2048
`define MREF_T1_KHZ 1544
`define TMR_W 24

`endif

// ==== rtl/loop_ctrl_pkg.sv ====
// Types of the loopback and in-band code controller.
package loop_ctrl_pkg;
  `include "loop_ctrl_params.svh"

  // Complete state of the controller.
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [2:0] clk_prev;
    logic [1:0] pattern_select;
    logic pattern_clock_select;
    logic e1_mode;
    logic analog_loop_enable;
    logic digital_loop_enable;
    logic remote_loop_enable;
    logic auto_remote_loop_enable;
    logic [1:0] tx_loop_code_length;
    logic [1:0] rx_activate_code_length;
    logic [1:0] rx_deactivate_code_length;
    logic [7:0] tx_loop_code_bits;
    logic [7:0] rx_activate_code_bits;
    logic [7:0] rx_deactivate_code_bits;
    logic activate_irq_edge_select;
    logic deactivate_irq_edge_select;
    logic [7:0] rdata;
    logic [2:0] tx_idx;
    logic [7:0] rx_hist;
    logic [4:0] act_gap;
    logic [4:0] deact_gap;
    logic [`TMR_W-1:0] act_tmr;
    logic [`TMR_W-1:0] deact_tmr;
    logic activate_code_detected;
    logic deactivate_code_detected;
    logic activate_irq_flag;
    logic deactivate_irq_flag;
    logic remote_loop_active;
    logic tx_line_data;
    logic tx_line_clk;
    logic rx_data_out;
    logic rx_clock_out;
    logic analog_loop;
    logic digital_loop;
    logic remote_loop;
  } state_s;
endpackage

// ==== rtl/loop_ctrl.sv ====
// Per-channel loopback selection, in-band loop code generation and code detection.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "loop_ctrl_params.svh"

// Function
// - Analog loop sends transmit signal into receiver; line keeps transmitting.
// - Pin mode, loop select pins 01 choose analog loop.
// - Digital loop feeds transmit data to receive outputs; line keeps transmitting.
// - Pin mode, loop select pins 10 choose digital loop.
// - Internal patterns still replace transmit data during analog or digital loop.
// - Remote loop sends recovered receive clock and data back to line.
// - Pin mode, loop select pins 11 choose remote loop.
// - Pattern select 11 repeatedly sends unframed loop code instead of data.
// - Receiver finds loop code framed or unframed, tolerating one percent errors.
// - Transmitted code comes from eight-bit register; no meaning attached.
// - Transmit code length five to eight bits; short codes repeated by software.
// - Code starts with pattern 11; stops with pattern 00 and clock select 0.
// - Activate code from eight-bit register with own two-bit length field.
// - Deactivate code from eight-bit register with own two-bit length field.
// - Activate status set after code held over 30 ms E1, 40 ms T1.
// - Deactivate status set after code held over 30 ms E1, 40 ms T1.
// - Edge select 0 flags rising status only; 1 flags any change.
// - Activate and deactivate flags clear when software reads them.
// - Auto loop holds until deactivate code over 5.1 s releases it.
// - Clearing auto enable tears down the automatically established remote loop.
// - Patterns use transmit clock, or master reference when clock select is 1.
module loop_ctrl
  import loop_ctrl_pkg::*;
#(
  parameter logic [`TMR_W-1:0] SHORT_E1_CNT = `TMR_W'(`QUAL_SHORT_E1_MS * `MREF_E1_KHZ),
  parameter logic [`TMR_W-1:0] SHORT_T1_CNT = `TMR_W'(`QUAL_SHORT_T1_MS * `MREF_T1_KHZ),
  parameter logic [`TMR_W-1:0] LONG_E1_CNT = `TMR_W'(`QUAL_LONG_MS * `MREF_E1_KHZ),
  parameter logic [`TMR_W-1:0] LONG_T1_CNT = `TMR_W'(`QUAL_LONG_MS * `MREF_T1_KHZ)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic tx_clock_in_i,
  input wire logic tx_data_i,
  input wire logic mref_clk_i,
  input wire logic rx_rec_clk_i,
  input wire logic rx_rec_data_i,
  input wire logic pin_mode_i,
  input wire logic [1:0] loop_select_pins_i,
  output logic tx_line_data_o,
  output logic tx_line_clk_o,
  output logic rx_single_rail_data_o,
  output logic rx_clock_out_o,
  output logic analog_loop_enable_o,
  output logic digital_loop_enable_o,
  output logic remote_loop_enable_o,
  output logic remote_loop_active_o,
  output logic activate_code_detected_o,
  output logic deactivate_code_detected_o
);

  // Number of bits in a code for a two-bit length field.
  function automatic logic [3:0] code_len(input logic [1:0] f);
    code_len = `CODE_LEN_BASE + {2'h0, f};
  endfunction

  // Exact match of the newest bits against the programmed code.
  function automatic logic code_match(input logic [7:0] hist, input logic [7:0] code,
                                      input logic [1:0] f);
    logic [7:0] mask;
    mask = `MASK_FULL >> (2'h3 - f);
    code_match = ((hist ^ code) & mask) == 8'h00;
  endfunction

  // Bits since the last match before the code counts as gone.
  function automatic logic [4:0] gap_limit(input logic [1:0] f);
    gap_limit = 5'(`GAP_PERIODS * code_len(f));
  endfunction

  // Next value of a qualification timer on a master reference edge.
  function automatic logic [`TMR_W-1:0] tmr_next(input logic [`TMR_W-1:0] t,
                                                 input logic present, input logic tick,
                                                 input logic [`TMR_W-1:0] top);
    if (!present) begin
      tmr_next = '0;
    end else if (tick && t <= top) begin
      tmr_next = t + `TMR_W'(1);
    end else begin
      tmr_next = t;
    end
  endfunction

  state_s q;
  state_s d;

  logic tx_edge;
  logic mref_edge;
  logic rx_edge;
  logic pat_edge;
  logic pin_mode;
  logic [1:0] pins;
  logic loop_a;
  logic loop_d;
  logic loop_r;
  logic act_present;
  logic deact_present;
  logic [`TMR_W-1:0] short_cnt;
  logic [`TMR_W-1:0] long_cnt;
  logic act_ev;
  logic deact_ev;
  logic flags_read;
  logic tx_bit;
  logic [7:0] rd_val;

  // Edge finding on synchronised clocks and decoding of the effective loop mode.
  always_comb begin
    tx_edge = q.sync2[`SY_TXCLK] && !q.clk_prev[0];
    mref_edge = q.sync2[`SY_MREF] && !q.clk_prev[1];
    rx_edge = q.sync2[`SY_RXCLK] && !q.clk_prev[2];
    pat_edge = q.pattern_clock_select ? mref_edge : tx_edge;
    pin_mode = q.sync2[`SY_PINMODE];
    pins = {q.sync2[`SY_LP1], q.sync2[`SY_LP0]};
    loop_a = pin_mode ? (pins == `PINS_ANALOG) : q.analog_loop_enable;
    loop_d = pin_mode ? (pins == `PINS_DIGITAL) : q.digital_loop_enable;
    loop_r = (pin_mode ? (pins == `PINS_REMOTE) : q.remote_loop_enable)
             || q.remote_loop_active;
    short_cnt = q.e1_mode ? SHORT_E1_CNT : SHORT_T1_CNT;
    long_cnt = q.e1_mode ? LONG_E1_CNT : LONG_T1_CNT;
    act_present = q.act_gap < gap_limit(q.rx_activate_code_length);
    deact_present = q.deact_gap < gap_limit(q.rx_deactivate_code_length);
    flags_read = rd_i && addr_i == `REG_IRQ_FLAGS;
  end

  // Transmit bit chosen on a pattern clock edge.
  always_comb begin
    case (q.pattern_select)
      `PATT_ONES: tx_bit = 1'b1;
      `PATT_PRBS: tx_bit = q.sync2[`SY_TXDATA];
      `PATT_LOOP: tx_bit = q.tx_loop_code_bits[q.tx_idx];
      default: tx_bit = q.pattern_clock_select ? 1'b0 : q.sync2[`SY_TXDATA];
    endcase
  end

  // Register read decode; unmapped offsets read as zero.
  always_comb begin
    case (addr_i)
      `REG_PATTERN_CTRL: rd_val = {4'h0, q.e1_mode, q.pattern_clock_select, q.pattern_select};
      `REG_LOOP_CTRL: rd_val = {4'h0, q.auto_remote_loop_enable, q.remote_loop_enable,
                                q.digital_loop_enable, q.analog_loop_enable};
      `REG_CODE_LENGTHS: rd_val = {2'h0, q.rx_deactivate_code_length,
                                   q.rx_activate_code_length, q.tx_loop_code_length};
      `REG_TX_CODE: rd_val = q.tx_loop_code_bits;
      `REG_RX_ACT_CODE: rd_val = q.rx_activate_code_bits;
      `REG_RX_DEACT_CODE: rd_val = q.rx_deactivate_code_bits;
      `REG_EDGE_SELECT: rd_val = {6'h00, q.deactivate_irq_edge_select,
                                  q.activate_irq_edge_select};
      `REG_DETECT_STATUS: rd_val = {6'h00, q.deactivate_code_detected,
                                    q.activate_code_detected};
      `REG_LOOP_STATUS: rd_val = {7'h00, q.remote_loop_active};
      `REG_IRQ_FLAGS: rd_val = {6'h00, q.deactivate_irq_flag, q.activate_irq_flag};
      default: rd_val = 8'h00;
    endcase
  end

  // Next state of the whole controller.
  always_comb begin
    d = q;
    d.sync1 = {loop_select_pins_i, pin_mode_i, rx_rec_data_i, rx_rec_clk_i,
               mref_clk_i, tx_data_i, tx_clock_in_i};
    d.sync2 = q.sync1;
    d.clk_prev = {q.sync2[`SY_RXCLK], q.sync2[`SY_MREF], q.sync2[`SY_TXCLK]};
    // Register writes.
    if (wr_i) begin
      case (addr_i)
        `REG_PATTERN_CTRL: begin
          d.pattern_select = wdata_i[`PC_PATT_HI:`PC_PATT_LO];
          d.pattern_clock_select = wdata_i[`PC_CLK_SEL];
          d.e1_mode = wdata_i[`PC_E1_MODE];
        end
        `REG_LOOP_CTRL: begin
          d.analog_loop_enable = wdata_i[`LC_ANALOG];
          d.digital_loop_enable = wdata_i[`LC_DIGITAL];
          d.remote_loop_enable = wdata_i[`LC_REMOTE];
          d.auto_remote_loop_enable = wdata_i[`LC_AUTO];
        end
        `REG_CODE_LENGTHS: begin
          d.tx_loop_code_length = wdata_i[`LEN_TX+1:`LEN_TX];
          d.rx_activate_code_length = wdata_i[`LEN_ACT+1:`LEN_ACT];
          d.rx_deactivate_code_length = wdata_i[`LEN_DEACT+1:`LEN_DEACT];
        end
        `REG_TX_CODE: d.tx_loop_code_bits = wdata_i;
        `REG_RX_ACT_CODE: d.rx_activate_code_bits = wdata_i;
        `REG_RX_DEACT_CODE: d.rx_deactivate_code_bits = wdata_i;
        `REG_EDGE_SELECT: begin
          d.activate_irq_edge_select = wdata_i[`BIT_ACT];
          d.deactivate_irq_edge_select = wdata_i[`BIT_DEACT];
        end
        default: begin
        end
      endcase
    end
    d.rdata = rd_i ? rd_val : 8'h00;
    // Transmit side: remote loop returns recovered data, else pattern or system data.
    if (loop_r) begin
      d.tx_line_clk = q.sync2[`SY_RXCLK];
      if (rx_edge) begin
        d.tx_line_data = q.sync2[`SY_RXDATA];
      end
    end else begin
      d.tx_line_clk = q.pattern_clock_select ? q.sync2[`SY_MREF] : q.sync2[`SY_TXCLK];
      if (pat_edge) begin
        d.tx_line_data = tx_bit;
        if (q.pattern_select != `PATT_LOOP || q.tx_idx == 3'h0) begin
          d.tx_idx = 3'(code_len(q.tx_loop_code_length) - 4'h1);
        end else begin
          d.tx_idx = q.tx_idx - 3'h1;
        end
      end
    end
    // Receive outputs: analog or digital loop returns the transmitted stream.
    if (loop_a || loop_d) begin
      d.rx_data_out = q.tx_line_data;
      d.rx_clock_out = q.tx_line_clk;
    end else begin
      d.rx_data_out = q.sync2[`SY_RXDATA];
      d.rx_clock_out = q.sync2[`SY_RXCLK];
    end
    d.analog_loop = loop_a;
    d.digital_loop = loop_d;
    d.remote_loop = loop_r;
    // Code detectors: shift received bits and track distance to last match.
    if (rx_edge) begin
      d.rx_hist = {q.rx_hist[6:0], q.sync2[`SY_RXDATA]};
      if (code_match(d.rx_hist, q.rx_activate_code_bits, q.rx_activate_code_length)) begin
        d.act_gap = 5'h00;
      end else if (q.act_gap != `GAP_MAX) begin
        d.act_gap = q.act_gap + 5'h01;
      end
      if (code_match(d.rx_hist, q.rx_deactivate_code_bits,
                     q.rx_deactivate_code_length)) begin
        d.deact_gap = 5'h00;
      end else if (q.deact_gap != `GAP_MAX) begin
        d.deact_gap = q.deact_gap + 5'h01;
      end
    end
    // Qualification timers on master reference edges.
    d.act_tmr = tmr_next(q.act_tmr, act_present, mref_edge, long_cnt);
    d.deact_tmr = tmr_next(q.deact_tmr, deact_present, mref_edge, long_cnt);
    d.activate_code_detected = q.act_tmr > short_cnt;
    d.deactivate_code_detected = q.deact_tmr > short_cnt;
    // Automatic remote loop is latched; only the deactivate code or software drops it.
    if (!q.auto_remote_loop_enable) begin
      d.remote_loop_active = 1'b0;
    end else if (q.act_tmr > long_cnt) begin
      d.remote_loop_active = 1'b1;
    end else if (q.deact_tmr > long_cnt) begin
      d.remote_loop_active = 1'b0;
    end
    // Status change events; a new event wins over the clearing read.
    act_ev = (d.activate_code_detected && !q.activate_code_detected)
             || (q.activate_irq_edge_select
                 && d.activate_code_detected != q.activate_code_detected);
    deact_ev = (d.deactivate_code_detected && !q.deactivate_code_detected)
               || (q.deactivate_irq_edge_select
                   && d.deactivate_code_detected != q.deactivate_code_detected);
    d.activate_irq_flag = act_ev || (q.activate_irq_flag && !flags_read);
    d.deactivate_irq_flag = deact_ev || (q.deactivate_irq_flag && !flags_read);
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.act_gap <= `GAP_MAX;
      q.deact_gap <= `GAP_MAX;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign rdata_o = q.rdata;
  assign tx_line_data_o = q.tx_line_data;
  assign tx_line_clk_o = q.tx_line_clk;
  assign rx_single_rail_data_o = q.rx_data_out;
  assign rx_clock_out_o = q.rx_clock_out;
  assign analog_loop_enable_o = q.analog_loop;
  assign digital_loop_enable_o = q.digital_loop;
  assign remote_loop_enable_o = q.remote_loop;
  assign remote_loop_active_o = q.remote_loop_active;
  assign activate_code_detected_o = q.activate_code_detected;
  assign deactivate_code_detected_o = q.deactivate_code_detected;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  pin_analog_a: assert property (pin_mode && pins == `PINS_ANALOG |=> analog_loop_enable_o)
    else $error("analog loop not selected by pins");
  pin_digital_a: assert property (pin_mode && pins == `PINS_DIGITAL |=> digital_loop_enable_o)
    else $error("digital loop not selected by pins");
  pin_remote_a: assert property (pin_mode && pins == `PINS_REMOTE |=> remote_loop_enable_o)
    else $error("remote loop not selected by pins");
  loop_code_a: assert property (q.pattern_select == `PATT_LOOP && !loop_r && pat_edge
                                |=> tx_line_data_o == $past(q.tx_loop_code_bits[q.tx_idx]))
    else $error("loop code bit not sent");
  remote_data_a: assert property (loop_r && rx_edge
                                  |=> tx_line_data_o == $past(q.sync2[`SY_RXDATA]))
    else $error("recovered data not returned to line");
  rx_loop_a: assert property ((loop_a || loop_d) ##1 (loop_a || loop_d)
                              |-> rx_single_rail_data_o == $past(tx_line_data_o))
    else $error("transmit data not looped to receive output");
  timer_restart_a: assert property (!act_present |=> q.act_tmr == '0)
    else $error("activate timer not restarted");
  status_set_a: assert property (q.act_tmr > short_cnt |=> activate_code_detected_o)
    else $error("activate status not set after qualification");
  auto_drop_a: assert property (!q.auto_remote_loop_enable |=> !remote_loop_active_o)
    else $error("auto remote loop kept after disable");
  rise_flag_a: assert property ($rose(activate_code_detected_o) |-> q.activate_irq_flag)
    else $error("activate flag not set on rising status");
  read_clear_a: assert property (flags_read && !act_ev |=> !q.activate_irq_flag)
    else $error("activate flag not cleared by read");

  // Transmit line and its clock while loops and patterns are active.
  line_keeps_a: assert property ((loop_a || loop_d) && !loop_r && pat_edge
      |=> tx_line_data_o == $past(tx_bit))
    else $error("line not driven during local loop");
  remote_clock_a: assert property (loop_r
      |=> tx_line_clk_o == $past(q.sync2[`SY_RXCLK]))
    else $error("recovered clock not on line");
  ones_sent_a: assert property (q.pattern_select == `PATT_ONES && !loop_r && pat_edge
      |=> tx_line_data_o)
    else $error("ones pattern not sent");
  zeros_sent_a: assert property (q.pattern_select == `PATT_NORMAL && !loop_r
      && q.pattern_clock_select && pat_edge |=> !tx_line_data_o)
    else $error("zeros not sent on master reference");
  mref_source_a: assert property (!loop_r && q.pattern_clock_select
      |=> tx_line_clk_o == $past(q.sync2[`SY_MREF]))
    else $error("pattern clock not master reference");
  code_wrap_a: assert property (q.pattern_select == `PATT_LOOP && !loop_r && pat_edge
      && q.tx_idx == 3'h0 && q.tx_loop_code_length == 2'h3 |=> q.tx_idx == 3'h7)
    else $error("eight-bit code not restarted at top bit");

  // Detectors, timers and status.
  act_match_a: assert property (rx_edge
      && code_match({q.rx_hist[6:0], q.sync2[`SY_RXDATA]}, q.rx_activate_code_bits,
                    q.rx_activate_code_length) |=> q.act_gap == 5'h00)
    else $error("activate match not recorded");
  deact_restart_a: assert property (!deact_present |=> q.deact_tmr == '0)
    else $error("deactivate timer not restarted");
  deact_status_a: assert property (q.deact_tmr > short_cnt
      |=> deactivate_code_detected_o)
    else $error("deactivate status not set");
  act_drop_a: assert property (q.act_tmr <= short_cnt |=> !activate_code_detected_o)
    else $error("activate status set too early");

  // Deactivate flag: edge selection and clear on read.
  deact_rise_a: assert property ($rose(deactivate_code_detected_o)
      |-> q.deactivate_irq_flag)
    else $error("deactivate flag not set on rise");
  fall_flag_a: assert property ($past(q.deactivate_irq_edge_select)
      && $fell(deactivate_code_detected_o) |-> q.deactivate_irq_flag)
    else $error("deactivate flag not set on fall");
  deact_clear_a: assert property (flags_read && !deact_ev |=> !q.deactivate_irq_flag)
    else $error("deactivate flag not cleared by read");

  // Automatic remote loop.
  auto_set_a: assert property (q.auto_remote_loop_enable && q.act_tmr > long_cnt
      |=> remote_loop_active_o ##1 remote_loop_enable_o)
    else $error("auto remote loop not established");
  auto_release_a: assert property (q.auto_remote_loop_enable && q.act_tmr <= long_cnt
      && q.deact_tmr > long_cnt |=> !remote_loop_active_o)
    else $error("auto remote loop not released");
  auto_hold_a: assert property (remote_loop_active_o && q.auto_remote_loop_enable
      && q.deact_tmr <= long_cnt |=> remote_loop_active_o)
    else $error("auto remote loop dropped early");

endmodule

// ==== bench/far_end_model.sv ====
// Far-end line equipment and the clock sources that face the loopback controller.
`timescale 1ns/1ps
module far_end_model (
  input wire logic [1:0] rx_mode_i,
  input wire logic [7:0] code_i,
  input wire logic [3:0] len_i,
  input wire logic tx_run_i,
  output logic tx_clock_o,
  output logic mref_clk_o,
  output logic rx_clk_o,
  output logic rx_data_o
);
  int idx;
  int cnt;

  // System transmit clock; it is held low while stopped.
  initial begin
    tx_clock_o = 1'b0;
    forever #80 tx_clock_o = tx_run_i & ~tx_clock_o;
  end

  // Free-running master reference, out of phase with the other clocks.
  initial begin
    mref_clk_o = 1'b0;
    #37;
    forever #80 mref_clk_o = ~mref_clk_o;
  end

  // Recovered receive stream: mode 1 repeats the code MSB first, 2 ones, 3 zeros.
  // Every hundredth code bit in mode 1 is corrupted; while idle the clock stands and data toggles.
  initial begin
    rx_clk_o = 1'b0;
    rx_data_o = 1'b0;
    idx = 0;
    cnt = 0;
    #13;
    forever begin
      #80 rx_clk_o = 1'b0;
      cnt = (cnt + 1) % 100;
      idx = (idx + 1) % len_i;
      case (rx_mode_i)
        2'h1: rx_data_o = code_i[len_i - 1 - idx] ^ (cnt == 0);
        2'h2: rx_data_o = 1'b1;
        2'h3: rx_data_o = 1'b0;
        default: rx_data_o = ~rx_data_o;
      endcase
      #80 rx_clk_o = (rx_mode_i != 2'h0);
    end
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench of the loopback and in-band code controller.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] TXC = 32'hE24E_0B13;
  logic clk, rst, wr, rd, tx_data, pin_mode, tx_run;
  logic [7:0] addr, wdata, rdata, code;
  logic [1:0] pins, rx_mode;
  logic [3:0] len;
  logic tx_clock, mref, rx_clk, rx_data, line_data, line_clk, rx_out, rx_clk_out;
  logic al, dl, rl, rla, act, deact;
  int bad_count, cmp_count;
  wire logic [3:0] flags = {rl, rla, deact, act};

  far_end_model far_end (.rx_mode_i(rx_mode), .code_i(code), .len_i(len), .tx_run_i(tx_run),
    .tx_clock_o(tx_clock), .mref_clk_o(mref), .rx_clk_o(rx_clk), .rx_data_o(rx_data));

  loop_ctrl #(.SHORT_E1_CNT(24'h00_0014), .SHORT_T1_CNT(24'h00_0018),
    .LONG_E1_CNT(24'h00_003C), .LONG_T1_CNT(24'h00_0046)) dut (.clk_i(clk), .rst_i(rst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .tx_clock_in_i(tx_clock), .tx_data_i(tx_data), .mref_clk_i(mref), .rx_rec_clk_i(rx_clk),
    .rx_rec_data_i(rx_data), .pin_mode_i(pin_mode), .loop_select_pins_i(pins),
    .tx_line_data_o(line_data), .tx_line_clk_o(line_clk), .rx_single_rail_data_o(rx_out),
    .rx_clock_out_o(rx_clk_out), .analog_loop_enable_o(al), .digital_loop_enable_o(dl),
    .remote_loop_enable_o(rl), .remote_loop_active_o(rla), .activate_code_detected_o(act),
    .deactivate_code_detected_o(deact));

  // System clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("read data", exp, rdata);
  endtask

  // Bounded wait for one status output; running out counts as a mismatch.
  task automatic wait_flag(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (flags[k] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("status flag", {7'h0, v}, {7'h0, flags[k]});
    if (flags[k] !== v) tally_and_finish();
  endtask

  // Samples the line mid-bit and looks for the code repeated at some rotation.
  task automatic tx_code_chk(input logic [7:0] c, input int l, input logic src);
    logic [23:0] b;
    logic hit, ok;
    repeat (10) @(negedge tx_clock or negedge mref);
    for (int k = 0; k < 24; k++) begin
      if (src) @(negedge mref);
      else @(negedge tx_clock);
      b[k] = line_data;
    end
    hit = 1'b0;
    for (int r = 0; r < l; r++) begin
      ok = 1'b1;
      for (int k = 0; k < 24; k++) if (b[k] !== c[l - 1 - ((k + r) % l)]) ok = 1'b0;
      if (ok) hit = 1'b1;
    end
    chk("tx code", 8'h01, {7'h0, hit});
  endtask

  // Far end sends the code that the local receive registers were set to match.
  task automatic send(input int k);
    code <= k[0] ? 8'h24 : 8'h10;
    len <= k[0] ? 4'h6 : 4'h5;
    rx_mode <= 2'h1;
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; tx_data = 1'b0;
    pin_mode = 1'b0; pins = 2'h0; tx_run = 1'b1; rx_mode = 2'h0; code = 8'h13; len = 4'h5;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h0F + i[7:0], 8'h00);
      wr_reg(8'h0F + i[7:0], 8'h5A ^ i[7:0]);
      rd_chk(8'h0F + i[7:0], 8'h5A ^ i[7:0]);
    end
    wr_reg(8'h16, 8'hFF);
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h20, 8'h00);
    // Pin-strapped loop selection.
    @(posedge clk);
    pin_mode <= 1'b1;
    for (int p = 1; p < 4; p++) begin
      @(posedge clk);
      pins <= p[1:0];
      repeat (8) @(negedge clk);
      chk("pin loop", 8'h01 << (p - 1), {5'h0, rl, dl, al});
    end
    @(posedge clk);
    pin_mode <= 1'b0;
    pins <= 2'h0;
    // Analog and digital loops return the ones pattern while the line carries it too.
    rx_mode <= 2'h3;
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h0D, 8'h01 << k);
      wr_reg(8'h0C, 8'h01);
      repeat (60) @(negedge clk);
      chk("looped data", 8'h03, {6'h0, line_data, rx_out});
      wr_reg(8'h0C, 8'h00);
      repeat (60) @(negedge clk);
      chk("looped data", 8'h00, {6'h0, line_data, rx_out});
    end
    wr_reg(8'h0D, 8'h04);
    rx_mode <= 2'h2;
    repeat (60) @(negedge clk);
    chk("remote loop", 8'h03, {6'h0, rl, line_data});
    wr_reg(8'h0D, 8'h00);
    // Loop code at every length, then on the master reference, then stopped.
    for (int f = 0; f < 4; f++) begin
      wr_reg(8'h0E, f[7:0]);
      wr_reg(8'h0F, TXC[8*f +: 8]);
      wr_reg(8'h0C, 8'h03);
      tx_code_chk(TXC[8*f +: 8], 5 + f, 1'b0);
    end
    tx_run <= 1'b0;
    wr_reg(8'h0C, 8'h07);
    tx_code_chk(8'hE2, 8, 1'b1);
    tx_run <= 1'b1;
    wr_reg(8'h0C, 8'h00);
    tx_data <= 1'b1;
    tx_code_chk(8'hFF, 5, 1'b0);
    wr_reg(8'h0C, 8'h04);
    tx_code_chk(8'h00, 5, 1'b1);
    // Each received code is qualified, reported, flagged on its edges, cleared on read.
    wr_reg(8'h0C, 8'h08);
    wr_reg(8'h0E, 8'h10);
    wr_reg(8'h10, 8'h10);
    wr_reg(8'h11, 8'h24);
    for (int k = 0; k < 2; k++) begin
      for (int e = 0; e < 2; e++) begin
        wr_reg(8'h15, e[0] ? 8'h01 << k : 8'h00);
        send(k);
        repeat (300) @(negedge clk);
        chk("early status", 8'h00, {7'h0, flags[k]});
        wait_flag(k, 1'b1, 2000);
        rd_chk(8'h16, 8'h01 << k);
        rd_chk(8'h18, 8'h01 << k);
        rd_chk(8'h18, 8'h00);
        rx_mode <= 2'h3;
        wait_flag(k, 1'b0, 2000);
        rd_chk(8'h18, e[0] ? 8'h01 << k : 8'h00);
      end
    end
    // Automatic remote loop: set by a long activate code, kept, released, forced off.
    wr_reg(8'h0C, 8'h00);
    wr_reg(8'h0D, 8'h08);
    send(0);
    repeat (1200) @(negedge clk);
    chk("early auto", 8'h00, {7'h0, rla});
    wait_flag(2, 1'b1, 3000);
    repeat (2) @(negedge clk);
    chk("auto loop", 8'h03, {6'h0, rl, act});
    rd_chk(8'h17, 8'h01);
    rx_mode <= 2'h3;
    repeat (1500) @(negedge clk);
    chk("auto kept", 8'h01, {7'h0, rla});
    send(1);
    wait_flag(2, 1'b0, 3000);
    repeat (2) @(negedge clk);
    chk("auto released", 8'h01, {6'h0, rl, deact});
    send(0);
    wait_flag(2, 1'b1, 3000);
    wr_reg(8'h0D, 8'h00);
    wait_flag(2, 1'b0, 10);
    tally_and_finish();
  end
endmodule
